// File: rtl/rofs_pkg.sv
package rofs_pkg;

  // ====================
  // Register offsets (byte addresses on the APB side)
  localparam logic [7:0] OFS_TRIP_MASK     = 8'h00; // Trip class mask
  localparam logic [7:0] OFS_RELAY_ONE     = 8'h04; // Relay one function code
  localparam logic [7:0] OFS_RELAY_TWO     = 8'h08; // Relay two function code
  localparam logic [7:0] OFS_ASSERT_DELAY  = 8'h0c; // Trip output on delay
  localparam logic [7:0] OFS_RELEASE_DELAY = 8'h10; // Trip output off delay
  localparam logic [7:0] OFS_STATUS        = 8'h14; // Live output state
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h18; // Sticky events, read clears
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h1c; // Interrupt enables

  // ====================
  // Function codes
  localparam int unsigned CODE_W = 6;
  localparam logic [5:0] CODE_RUN        = 6'h0e; // 14 running indication
  localparam logic [5:0] CODE_TIMER      = 6'h1c; // 28 input timer
  localparam logic [5:0] CODE_TRIP       = 6'h1d; // 29 fault trip
  localparam logic [5:0] CODE_ONOFF      = 6'h22; // 34 analog comparison
  localparam logic [5:0] CODE_BRAKE      = 6'h23; // 35 brake release
  localparam logic [5:0] CODE_OVERRIDE   = 6'h26; // 38 emergency override
  localparam logic [5:0] CODE_BUFFERING  = 6'h28; // 40 energy buffering
  localparam logic [5:0] CODE_WARNING    = 6'h2a; // 42 minor fault
  localparam logic [5:0] CODE_DORMANT    = 6'h2d; // 45 loop controller sleep
  localparam logic [5:0] CODE_MAX        = 6'h2d; // Highest accepted code
  localparam logic [5:0] RELAY_ONE_RST   = CODE_TRIP;
  localparam logic [5:0] RELAY_TWO_RST   = CODE_RUN;

  // ====================
  // Trip class mask: field bit 0 is class bit1, field bit 1 is class bit2
  localparam int unsigned MASK_W       = 3;
  localparam int unsigned MASK_UV      = 0; // Undervoltage trips
  localparam int unsigned MASK_OTHER   = 1; // All other trips
  localparam logic [2:0]  MASK_RST     = 3'h2; // Pattern 010

  // ====================
  // Delays in 0.01 s steps
  localparam int unsigned DELAY_W       = 14;
  localparam logic [13:0] DELAY_MAX     = 14'h2710; // 100.00 s
  localparam logic [13:0] DELAY_RST     = 14'h0000; // 0.00 s
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          DELAY_STEP_NS = 10_000_000; // 0.01 s
  localparam int          TICK_CYCLES   = DELAY_STEP_NS / CLK_PERIOD_NS;

  // ====================
  // Status and interrupt bit positions
  localparam int unsigned ST_RELAY_ONE  = 0;
  localparam int unsigned ST_RELAY_TWO  = 1;
  localparam int unsigned ST_TRIP_QUAL  = 2;
  localparam int unsigned ST_TRIP_OUT   = 3;
  localparam int unsigned IRQ_W         = 5;
  localparam int unsigned IRQ_ONE_RISE  = 0;
  localparam int unsigned IRQ_ONE_FALL  = 1;
  localparam int unsigned IRQ_TWO_RISE  = 2;
  localparam int unsigned IRQ_TWO_FALL  = 3;
  localparam int unsigned IRQ_TRIP_RISE = 4;
  localparam logic [4:0]  IRQ_RST       = 5'h00;

  // Drive conditions feeding the selector
  typedef struct packed {
    logic fault_trip_uv;           // Undervoltage trip present
    logic fault_trip_other;        // Any other trip present
    logic emergency_override;      // Override operating state
    logic energy_buffering_active; // Buffering after input loss
    logic warning_active;          // Minor fault
    logic loop_controller_dormant; // Loop controller asleep
    logic brake_release_output;    // Brake release command
    logic onoff_compare;           // Analog comparison result
    logic timer_output;            // Input timer result
    logic run_command;             // Run command present
    logic output_voltage;          // Drive producing voltage
    logic dc_braking;              // DC braking in progress
  } rofs_cond_t;

endpackage

// File: rtl/rofs_tick.sv
module rofs_tick #(
  parameter int TICK_CYCLES = rofs_pkg::TICK_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  // ====================
  // Prescaler
  logic [31:0] count; // Cycles within one step

  // Free running step pulse, one cycle wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == 32'(TICK_CYCLES - 1)) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end

endmodule

// File: rtl/rofs_delay.sv
module rofs_delay (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        req,
  input  wire logic [13:0] on_delay,
  input  wire logic [13:0] off_delay,
  output logic             out
);

  // ====================
  // On/off delay state machine
  typedef enum logic [1:0] {OFF, WAIT_ON, ON, WAIT_OFF} rofs_dly_t;

  rofs_dly_t   state; // Current phase
  logic [13:0] count; // Steps seen while waiting

  // Switch on the step after the count reaches the delay: at least the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= OFF;
      count <= 14'h0000;
      out   <= 1'b0;
    end else begin
      unique case (state)
        OFF: begin
          count <= 14'h0000;
          if (req && on_delay == 14'h0000) begin
            state <= ON;
            out   <= 1'b1;
          end else if (req) begin
            state <= WAIT_ON;
          end
        end
        WAIT_ON: begin
          if (!req) begin
            state <= OFF;
          end else if (tick && count == on_delay) begin
            state <= ON;
            out   <= 1'b1;
          end else if (tick) begin
            count <= count + 14'h0001;
          end
        end
        ON: begin
          count <= 14'h0000;
          if (!req && off_delay == 14'h0000) begin
            state <= OFF;
            out   <= 1'b0;
          end else if (!req) begin
            state <= WAIT_OFF;
          end
        end
        WAIT_OFF: begin
          if (req) begin
            state <= ON;
          end else if (tick && count == off_delay) begin
            state <= OFF;
            out   <= 1'b0;
          end else if (tick) begin
            count <= count + 14'h0001;
          end
        end
      endcase
    end
  end

endmodule

// File: rtl/rofs_top.sv
// Functional notes
// - Code 29 asserts relay after fault trip
// - Code 38 follows emergency override state
// - Code 40 follows energy buffering after power loss
// - Code 42 follows warning condition
// - Code 45 follows loop controller dormant
// - Code 35 follows brake release command
// - Code 34 follows analog comparison result
// - Code 28 follows input triggered timer
// - Relay one accepts 0-45, resets to 29
// - Relay two accepts 0-45, resets to 14
// - Trip on delay 0-100 s, 0.01 s
// - Trip off delay 0-100 s, 0.01 s
// - Trip class mask resets to 010
// - Mask bit1 enables undervoltage trips
// - Mask bit2 enables all other trips
// - Code 14: running with voltage, not braking
//
// Local design decisions: register access over APB and the address map.
module rofs_top #(
  parameter int TICK_CYCLES = rofs_pkg::TICK_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire rofs_pkg::rofs_cond_t conditions,
  output logic                     relay_one,
  output logic                     relay_two,
  output logic                     irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [2:0]  trip_output_class_mask;    // Trip classes that qualify
  logic [5:0]  relay_one_function_code;   // Relay one selection
  logic [5:0]  relay_two_function_code;   // Relay two selection
  logic [13:0] trip_output_assert_delay;  // On delay in steps
  logic [13:0] trip_output_release_delay; // Off delay in steps
  logic [4:0]  irq_status;                // Sticky events
  logic [4:0]  irq_mask;                  // Interrupt enables
  logic        trip_qualified;            // Trip of an enabled class
  logic        trip_delayed;              // Trip after on/off delays
  logic        tick;                      // One pulse per 0.01 s
  logic        next_relay_one;            // Relay one next value
  logic        next_relay_two;            // Relay two next value
  logic [4:0]  events;                    // Events this cycle
  logic [4:0]  next_irq_status;           // Status after set and clear
  logic        access_done;               // Completing APB edge
  logic        wr_commit;                 // Write takes effect
  logic        rd_irq_clear;              // Read of sticky status ends
  logic        next_err;                  // Error for the pending access
  logic [31:0] next_rdata;                // Read data for the pending access

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Map a function code to the relay level it selects
  function automatic logic select_relay(
    input logic [5:0]           code,
    input rofs_pkg::rofs_cond_t cond,
    input logic                 trip
  );
    logic level;
    level = 1'b0;
    case (code)
      rofs_pkg::CODE_RUN: begin
        level = cond.run_command & cond.output_voltage & ~cond.dc_braking;
      end
      rofs_pkg::CODE_TIMER: begin
        level = cond.timer_output;
      end
      rofs_pkg::CODE_TRIP: begin
        level = trip;
      end
      rofs_pkg::CODE_ONOFF: begin
        level = cond.onoff_compare;
      end
      rofs_pkg::CODE_BRAKE: begin
        level = cond.brake_release_output;
      end
      rofs_pkg::CODE_OVERRIDE: begin
        level = cond.emergency_override;
      end
      rofs_pkg::CODE_BUFFERING: begin
        level = cond.energy_buffering_active;
      end
      rofs_pkg::CODE_WARNING: begin
        level = cond.warning_active;
      end
      rofs_pkg::CODE_DORMANT: begin
        level = cond.loop_controller_dormant;
      end
      default: begin
        level = 1'b0;
      end
    endcase
    return level;
  endfunction

  // True when a written value fits within a limit
  function automatic logic fits(
    input logic [31:0] value,
    input logic [31:0] limit
  );
    return value <= limit;
  endfunction

  // ==========================================================================
  // Submodules
  // ==========================================================================
  // Step pulse for the delays
  rofs_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // on and off delay of the trip
  rofs_delay u_delay (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick),
    .req       (trip_qualified),
    .on_delay  (trip_output_assert_delay),
    .off_delay (trip_output_release_delay),
    .out       (trip_delayed)
  );

  // ==========================================================================
  // Trip qualification
  // ==========================================================================
  // undervoltage class; other classes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_qualified <= 1'b0;
    end else begin
      trip_qualified <=
        (trip_output_class_mask[rofs_pkg::MASK_UV] & conditions.fault_trip_uv) |
        (trip_output_class_mask[rofs_pkg::MASK_OTHER] & conditions.fault_trip_other);
    end
  end

  // ==========================================================================
  // Relay selection
  // ==========================================================================
  // Next relay levels from the selected conditions
  always_comb begin
    next_relay_one = select_relay(relay_one_function_code, conditions, trip_delayed);
    next_relay_two = select_relay(relay_two_function_code, conditions, trip_delayed);
  end

  // Registered relay outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_one <= 1'b0;
      relay_two <= 1'b0;
    end else begin
      relay_one <= next_relay_one;
      relay_two <= next_relay_two;
    end
  end

  // ==========================================================================
  // APB decode
  // ==========================================================================
  // Access phase completion and its effects
  always_comb begin
    access_done  = psel & penable & pready;
    wr_commit    = access_done & pwrite & ~pslverr;
    rd_irq_clear = access_done & ~pwrite & ~pslverr &
                   (paddr == rofs_pkg::OFS_IRQ_STATUS);
  end

  // Read data and error for the current address
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (paddr)
      rofs_pkg::OFS_TRIP_MASK: begin
        next_rdata[2:0] = trip_output_class_mask;
      end
      rofs_pkg::OFS_RELAY_ONE: begin
        next_rdata[5:0] = relay_one_function_code;
        next_err = pwrite & ~fits(pwdata, {26'h0000000, rofs_pkg::CODE_MAX});
      end
      rofs_pkg::OFS_RELAY_TWO: begin
        next_rdata[5:0] = relay_two_function_code;
        next_err = pwrite & ~fits(pwdata, {26'h0000000, rofs_pkg::CODE_MAX});
      end
      rofs_pkg::OFS_ASSERT_DELAY: begin
        next_rdata[13:0] = trip_output_assert_delay;
        next_err = pwrite & ~fits(pwdata, {18'h00000, rofs_pkg::DELAY_MAX});
      end
      rofs_pkg::OFS_RELEASE_DELAY: begin
        next_rdata[13:0] = trip_output_release_delay;
        next_err = pwrite & ~fits(pwdata, {18'h00000, rofs_pkg::DELAY_MAX});
      end
      // Live state, writes ignored
      rofs_pkg::OFS_STATUS: begin
        next_rdata[rofs_pkg::ST_RELAY_ONE] = relay_one;
        next_rdata[rofs_pkg::ST_RELAY_TWO] = relay_two;
        next_rdata[rofs_pkg::ST_TRIP_QUAL] = trip_qualified;
        next_rdata[rofs_pkg::ST_TRIP_OUT]  = trip_delayed;
      end
      // Sticky events, writes ignored
      rofs_pkg::OFS_IRQ_STATUS: begin
        next_rdata[4:0] = irq_status;
      end
      rofs_pkg::OFS_IRQ_MASK: begin
        next_rdata[4:0] = irq_mask;
      end
      // Unmapped address
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= next_err;
      prdata  <= (pwrite || next_err) ? 32'h0000_0000 : next_rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // trip class mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_output_class_mask <= rofs_pkg::MASK_RST;
    end else if (wr_commit && paddr == rofs_pkg::OFS_TRIP_MASK) begin
      trip_output_class_mask <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_one_function_code <= rofs_pkg::RELAY_ONE_RST;
    end else if (wr_commit && paddr == rofs_pkg::OFS_RELAY_ONE) begin
      relay_one_function_code <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_two_function_code <= rofs_pkg::RELAY_TWO_RST;
    end else if (wr_commit && paddr == rofs_pkg::OFS_RELAY_TWO) begin
      relay_two_function_code <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_output_assert_delay  <= rofs_pkg::DELAY_RST;
      trip_output_release_delay <= rofs_pkg::DELAY_RST;
    end else if (wr_commit && paddr == rofs_pkg::OFS_ASSERT_DELAY) begin
      trip_output_assert_delay  <= pwdata[13:0];
    end else if (wr_commit && paddr == rofs_pkg::OFS_RELEASE_DELAY) begin
      trip_output_release_delay <= pwdata[13:0];
    end
  end

  // Interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= rofs_pkg::IRQ_RST;
    end else if (wr_commit && paddr == rofs_pkg::OFS_IRQ_MASK) begin
      irq_mask <= pwdata[4:0];
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  // Previous delayed trip for edge detection
  logic trip_delayed_q;

  // Rising edge of the delayed trip
  function automatic logic u_delay_rise();
    return trip_delayed & ~trip_delayed_q;
  endfunction

  // Edge events; only bits returned by the read are cleared, new sets win
  always_comb begin
    events = 5'h00;
    events[rofs_pkg::IRQ_ONE_RISE]  = next_relay_one & ~relay_one;
    events[rofs_pkg::IRQ_ONE_FALL]  = ~next_relay_one & relay_one;
    events[rofs_pkg::IRQ_TWO_RISE]  = next_relay_two & ~relay_two;
    events[rofs_pkg::IRQ_TWO_FALL]  = ~next_relay_two & relay_two;
    events[rofs_pkg::IRQ_TRIP_RISE] = u_delay_rise();
    next_irq_status = (irq_status & ~(rd_irq_clear ? prdata[4:0] : 5'h00)) | events;
  end

  // Sticky status, delayed trip history and the interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status     <= rofs_pkg::IRQ_RST;
      trip_delayed_q <= 1'b0;
      irq            <= 1'b0;
    end else begin
      irq_status     <= next_irq_status;
      trip_delayed_q <= trip_delayed;
      irq            <= |(next_irq_status & irq_mask);
    end
  end

endmodule

// File: testbench/rofs_monitor.sv
module rofs_monitor (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire rofs_pkg::rofs_cond_t conditions,
  input wire logic                 relay_one,
  input wire logic                 relay_two,
  input wire logic                 irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Shadow state
  logic [5:0] code_one; // Committed relay one code
  logic [5:0] code_two; // Committed relay two code
  logic       up;       // Set from the first edge after reset
  logic       done;     // Transfer completes at this edge
  assign done = psel && penable && pready;
  // Follow accepted code writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_one <= rofs_pkg::RELAY_ONE_RST;
      code_two <= rofs_pkg::RELAY_TWO_RST;
      up       <= 1'b0;
    end else begin
      up <= 1'b1;
      if (done && pwrite && !pslverr && paddr == 8'h04) begin
        code_one <= pwdata[5:0];
      end
      if (done && pwrite && !pslverr && paddr == 8'h08) begin
        code_two <= pwdata[5:0];
      end
    end
  end
  // Relay level for every code but the trip code
  function automatic logic sel(input logic [5:0] c, input rofs_pkg::rofs_cond_t k);
    case (c)
      6'h0e:   return k.run_command & k.output_voltage & ~k.dc_braking;
      6'h1c:   return k.timer_output;
      6'h22:   return k.onoff_compare;
      6'h23:   return k.brake_release_output;
      6'h26:   return k.emergency_override;
      6'h28:   return k.energy_buffering_active;
      6'h2a:   return k.warning_active;
      6'h2d:   return k.loop_controller_dormant;
      default: return 1'b0;
    endcase
  endfunction
  // ====================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready too long");
  property p_wait_state;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("no wait state");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("stray read data");
  property p_unmapped;
    done && paddr > rofs_pkg::OFS_IRQ_MASK |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped accepted");
  property p_code_range;
    done && pwrite && (paddr == 8'h04 || paddr == 8'h08) && pwdata > 32'h2d |-> pslverr;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("code above range accepted");
  property p_relay_one;
    up && $past(code_one) != 6'h1d |-> relay_one == sel($past(code_one), $past(conditions));
  endproperty
  a_relay_one: assert property (p_relay_one)
    else $error("relay one wrong");
  property p_relay_two;
    up && $past(code_two) != 6'h1d |-> relay_two == sel($past(code_two), $past(conditions));
  endproperty
  a_relay_two: assert property (p_relay_two)
    else $error("relay two wrong");
  // Main scenarios reached
  c_refused: cover property (done && pslverr);
  c_trip: cover property (relay_one && code_one == 6'h1d);
  c_irq: cover property (irq);
endmodule

bind rofs_top rofs_monitor i_rofs_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .conditions, .relay_one, .relay_two, .irq);

// File: testbench/rofs_equipment.sv
module rofs_equipment (
  input wire logic        pclk,
  input wire logic        relay_one,
  input wire logic        relay_two,
  output logic     [15:0] pickups
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] coil = 2'h0; // Last coil levels
  initial pickups = 16'h0;
  // Count contact closures of both relays
  always @(posedge pclk) begin
    pickups <= pickups + 16'(relay_one & ~coil[0]) + 16'(relay_two & ~coil[1]);
    coil    <= {relay_two, relay_one};
  end
endmodule

// File: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Signals
  localparam int          TC  = 4;              // Short delay step
  localparam logic [33:0] ALL = 34'h1_ffff_ffff; // Error and data
  localparam logic [33:0] ST  = 34'h1_0000_0003; // Relay status bits
  localparam logic [33:0] TR  = 34'h1_0000_000d; // Trip status bits
  localparam logic [33:0] IQ  = 34'h2_0000_0001; // Irq and first event
  logic                 pclk       = 1'b0;
  logic                 presetn    = 1'b0;
  logic                 psel       = 1'b0;
  logic                 penable    = 1'b0;
  logic                 pwrite     = 1'b0;
  logic [7:0]           paddr      = 8'h00;
  logic [31:0]          pwdata     = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 relay_one;
  logic                 relay_two;
  logic                 irq;
  rofs_pkg::rofs_cond_t conditions = '0;
  rofs_pkg::rofs_cond_t c;          // Random condition set
  logic [12:0]          ext;        // Conditions with a spare zero
  logic [67:0]          note;       // Oldest expectation
  logic [67:0]          exp_q[$];   // Expected values and masks
  int                   seed       = 32'h110e7e99;
  int                   fail_count = 0;
  int                   tests_run  = 0;
  int                   cycles     = 0;
  logic [5:0]           codes [10] = '{6'h1c, 6'h22, 6'h23, 6'h26, 6'h28, 6'h2a, 6'h2d,
                                       6'h00, 6'h1f, 6'h2b};
  int                   pos [10]   = '{3, 4, 5, 9, 8, 7, 6, 12, 12, 12};
  always #5 pclk = ~pclk;
  rofs_top #(.TICK_CYCLES(TC)) i_rofs_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .conditions, .relay_one, .relay_two, .irq);
  rofs_equipment i_rofs_equipment (.pclk, .relay_one, .relay_two, .pickups());
  // ====================
  // Tasks
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One transfer, expectation noted first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back({e & m, m});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {1'b0, err, 32'h0}, 34'h1_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask
  task automatic go(input rofs_pkg::rofs_cond_t k);
    conditions <= k;
    repeat (4) @(posedge pclk);
  endtask
  // Compare every completed transfer
  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check({irq, pslverr, prdata} & note[33:0], note[67:34]);
    end
  end
  // Cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  // ====================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 34'h2, ALL);
    rd(8'h04, 34'h1d, ALL);
    rd(8'h08, 34'h0e, ALL);
    rd(8'h0c, 34'h0, ALL);
    rd(8'h10, 34'h0, ALL);
    wr(8'h08, 32'h2e, 1'b1);
    rd(8'h08, 34'h0e, ALL);
    wr(8'h0c, 32'h2711, 1'b1);
    wr(8'h10, 32'h2710, 1'b0);
    rd(8'h10, 34'h2710, ALL);
    rd(8'h20, 34'h1_0000_0000, ALL);
    // Direct codes and unused codes under random conditions
    for (int i = 0; i < 10; i++) begin
      wr(8'h04, 32'(codes[i]), 1'b0);
      repeat (4) begin
        c = rofs_pkg::rofs_cond_t'($random(seed) & 12'h3ff);
        ext = {1'b0, c};
        go(c);
        rd(8'h14, {32'h0, c.run_command & c.output_voltage & ~c.dc_braking, ext[pos[i]]},
           ST);
      end
    end
    // Trip classes, then delays
    wr(8'h04, 32'h1d, 1'b0);
    wr(8'h10, 32'h0, 1'b0);
    go(12'h800);
    rd(8'h14, 34'h0, TR);
    go(12'h400);
    rd(8'h14, 34'hd, TR);
    go(12'h000);
    wr(8'h00, 32'h1, 1'b0);
    go(12'h800);
    rd(8'h14, 34'hd, TR);
    go(12'h000);
    rd(8'h14, 34'h0, TR);
    wr(8'h0c, 32'h2, 1'b0);
    wr(8'h10, 32'h2, 1'b0);
    go(12'h800);
    rd(8'h14, 34'h4, TR);
    repeat (16) @(posedge pclk);
    rd(8'h14, 34'hd, TR);
    go(12'h000);
    rd(8'h14, 34'h9, TR);
    repeat (16) @(posedge pclk);
    rd(8'h14, 34'h0, TR);
    // Interrupt raised, cleared and masked
    wr(8'h04, 32'h2a, 1'b0);
    wr(8'h1c, 32'h1, 1'b0);
    rd(8'h18, 34'h2_0000_0001, IQ);
    go(12'h080);
    rd(8'h18, 34'h2_0000_0001, IQ);
    rd(8'h14, 34'h0, 34'h2_0000_0000);
    wr(8'h1c, 32'h0, 1'b0);
    go(12'h000);
    go(12'h080);
    rd(8'h18, 34'h1, IQ);
    print_verdict;
  end
endmodule
